// >>> pic_consts.vh
// constants for the prioritized interrupt controller
// assumes a 32-bit axi4-lite slave port on a 100 MHz clock
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PIC_OFF_ENABLE_ZERO 8'h00
`define PIC_OFF_ENABLE_ONE 8'h04
`define PIC_OFF_PRIO_HIGH_ZERO 8'h08
`define PIC_OFF_PRIO_HIGH_ONE 8'h0C
`define PIC_OFF_PRIO_LOW_ZERO 8'h10
`define PIC_OFF_PRIO_LOW_ONE 8'h14
`define PIC_OFF_TIMER_CONTROL 8'h18
`define PIC_OFF_CORE 8'h1C
`define PIC_OFF_STATUS 8'h20
`define PIC_OFF_MASK 8'h24
`define PIC_OFF_SRC_SET 8'h28
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PIC_BIT_GLOBAL_EN 7
`define PIC_BIT_EXT_EN_ZERO 0
`define PIC_BIT_EXT_EN_ONE 2
`define PIC_BIT_TRIG_ZERO 0
`define PIC_BIT_REQ_ZERO 1
`define PIC_BIT_TRIG_ONE 2
`define PIC_BIT_REQ_ONE 3
`define PIC_BIT_RETURN_FROM_INTERRUPT_INSTRUCTION 0
`define PIC_BIT_ST_GRANT 0
`define PIC_BIT_ST_RETURN 1
`define PIC_BIT_ST_EXT 2
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define PIC_RST_BYTE 8'h00
`define PIC_VEC_BASE 16'h0003
`define PIC_CLK_PERIOD_NS 10
`define PIC_PCYCLE_CLKS 3'h6
`define PIC_NUM_SRC 15
`endif

// >>> pic_intc.v
// prioritized interrupt controller: 15 sources, four levels, nesting
// assumes a core that samples irq_req_o at instruction boundaries and
// pulses grant/return; pins are asynchronous and synchronised here
// Functional notes
// - every source event latches into a pending flag held until cleared; here events on sources 13,14 are dropped and never latch
// - core finishes current instruction, saves pc, jumps to granted vector
// - return instruction releases in-progress level and resumes saved pc
// - high,low priority bits map 00..11 to levels 0..3
// - only a strictly higher level preempts a running routine
// - highest programmed level among enabled pending requests wins
// - equal levels resolved by polling order 0..14, vectors 8 bytes apart
// - two enable registers, four priority registers of 8 bits
// - trigger bit 0 means low level, 1 means falling edge
// - external request arbitrates only while its enable bit is set
// - detected pin event sets its request flag in timer control
// - edge request flag clears by hardware on vectoring
// - low level on either pin raises a wake output
// - pins and keyboard inputs sampled once per six-clock cycle
// - global enable gates all sources before individual enables
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pic_consts.vh"
module pic_intc (
  // clock, reset, enable
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // external pins and internal sources
  input wire ext_request_pin_zero_n_i,
  input wire ext_request_pin_one_n_i,
  input wire [3:0] keyboard_inputs_i,
  input wire [14:0] src_pulse_i,
  // execution unit
  output wire irq_req_o,
  output reg [15:0] irq_vector_o,
  input wire irq_grant_i,
  input wire irq_return_i,
  output reg [3:0] kbd_sampled_o,
  output wire wake_o,
  output wire irq_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [1:0] lvl_of;
    input hi;
    input lo;
    begin
      lvl_of = {hi, lo};
    end
  endfunction
  function [2:0] top_level;
    input [3:0] mask;
    begin
      top_level = mask[3] ? 3'h3 : mask[2] ? 3'h2 : mask[1] ? 3'h1 : mask[0] ? 3'h0 : 3'h4;
    end
  endfunction
  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  reg [7:0] enable_reg_zero, enable_reg_one;
  reg [7:0] prio_high_reg_zero, prio_high_reg_one, prio_low_reg_zero, prio_low_reg_one;
  reg [3:0] timer_control_register;
  reg [14:0] pending;
  reg [3:0] in_progress;
  reg [2:0] status, mask;
  reg [2:0] pcnt;
  reg [1:0] sync0, sync1;
  reg [7:0] kbd_sync;
  reg last0, last1;
  reg aw_hold, w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  wire [14:0] src_en = {2'h0, enable_reg_one[5:0], enable_reg_zero[6:0]};
  wire [14:0] src_hi = {2'h0, prio_high_reg_one[5:0], prio_high_reg_zero[6:0]};
  wire [14:0] src_lo = {2'h0, prio_low_reg_one[5:0], prio_low_reg_zero[6:0]};
  // sources 13,14 reserved: never enabled
  wire [14:0] eligible = pending & src_en &
                         {15{enable_reg_zero[`PIC_BIT_GLOBAL_EN]}};
  reg [3:0] win_idx;
  reg [1:0] win_lvl;
  reg win_any;
  integer i;
  always @* begin
    win_idx = 4'h0;
    win_lvl = 2'h0;
    win_any = 1'b0;
    // scan from lowest number, replace only on strictly higher level
    for (i = 0; i < `PIC_NUM_SRC; i = i + 1) begin
      if (eligible[i] && (!win_any || lvl_of(src_hi[i], src_lo[i]) > win_lvl)) begin
        win_any = 1'b1;
        win_idx = i[3:0];
        win_lvl = lvl_of(src_hi[i], src_lo[i]);
      end
    end
  end
  wire [2:0] cur_top = top_level(in_progress);
  // preempt only if strictly above the active level
  assign irq_req_o = win_any && (cur_top == 3'h4 || {1'b0, win_lvl} > cur_top);
  always @* begin
    irq_vector_o = `PIC_VEC_BASE + {9'h000, win_idx, 3'h0};
  end
  wire take = ce_i && irq_grant_i && irq_req_o;
  wire leave = ce_i && irq_return_i;
  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  wire tick = (pcnt == `PIC_PCYCLE_CLKS - 3'h1);
  // event on sample edge; sampling once per cycle filters short glitches
  wire ev0 = tick && (timer_control_register[`PIC_BIT_TRIG_ZERO] ?
                      (last0 && !sync0[1]) : !sync0[1]);
  wire ev1 = tick && (timer_control_register[`PIC_BIT_TRIG_ONE] ?
                      (last1 && !sync1[1]) : !sync1[1]);
  assign wake_o = !sync0[1] || !sync1[1];
  // ---------------------------------------------------------------
  // axi4-lite
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = ce_i && aw_hold && w_hold && !s_axi_bvalid;
  wire do_rd = ce_i && s_axi_arvalid && s_axi_arready;
  wire wsel_tc = do_wr && w_strb[0] && aw_addr == `PIC_OFF_TIMER_CONTROL;
  wire wsel_src = do_wr && w_strb[0] && aw_addr == `PIC_OFF_SRC_SET;
  wire rd_status = do_rd && s_axi_araddr == `PIC_OFF_STATUS;
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `PIC_OFF_ENABLE_ZERO: rd_val[7:0] = enable_reg_zero;
      `PIC_OFF_ENABLE_ONE: rd_val[7:0] = enable_reg_one;
      `PIC_OFF_PRIO_HIGH_ZERO: rd_val[7:0] = prio_high_reg_zero;
      `PIC_OFF_PRIO_HIGH_ONE: rd_val[7:0] = prio_high_reg_one;
      `PIC_OFF_PRIO_LOW_ZERO: rd_val[7:0] = prio_low_reg_zero;
      `PIC_OFF_PRIO_LOW_ONE: rd_val[7:0] = prio_low_reg_one;
      `PIC_OFF_TIMER_CONTROL: rd_val[3:0] = timer_control_register;
      `PIC_OFF_CORE: rd_val[18:0] = {in_progress, pending};
      `PIC_OFF_STATUS: rd_val[2:0] = status;
      `PIC_OFF_MASK: rd_val[2:0] = mask;
      `PIC_OFF_SRC_SET: rd_val[14:0] = pending;
      default: rd_ok = 1'b0;
    endcase
  end
  wire wr_ok = aw_addr <= `PIC_OFF_SRC_SET && aw_addr[1:0] == 2'h0;
  assign irq_o = |(status & mask);
  // ---------------------------------------------------------------
  // sequential
  // ---------------------------------------------------------------
  reg [14:0] next_pending;
  always @* begin
    next_pending = pending;
    // edge sources clear on vectoring; levels stay for software
    if (take && (win_idx != 4'h0 || timer_control_register[`PIC_BIT_TRIG_ZERO]) &&
        (win_idx != 4'h2 || timer_control_register[`PIC_BIT_TRIG_ONE]))
      next_pending[win_idx] = 1'b0;
    if (wsel_src)
      next_pending = next_pending & ~w_data[14:0];
    if (wsel_tc) begin
      next_pending[0] = w_data[`PIC_BIT_REQ_ZERO];
      next_pending[2] = w_data[`PIC_BIT_REQ_ONE];
    end
    // sets win over any clear in the same cycle
    next_pending = next_pending | src_pulse_i;
    if (ev0)
      next_pending[0] = 1'b1;
    if (ev1)
      next_pending[2] = 1'b1;
    next_pending[14:13] = 2'h0;
  end
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      enable_reg_zero <= `PIC_RST_BYTE;
      enable_reg_one <= `PIC_RST_BYTE;
      prio_high_reg_zero <= `PIC_RST_BYTE;
      prio_high_reg_one <= `PIC_RST_BYTE;
      prio_low_reg_zero <= `PIC_RST_BYTE;
      prio_low_reg_one <= `PIC_RST_BYTE;
      timer_control_register <= 4'h0;
      pending <= 15'h0000;
      in_progress <= 4'h0;
      status <= 3'h0;
      mask <= 3'h0;
      pcnt <= 3'h0;
      sync0 <= 2'h3;
      sync1 <= 2'h3;
      kbd_sync <= 8'h00;
      last0 <= 1'b1;
      last1 <= 1'b1;
      kbd_sampled_o <= 4'hF;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (ce_i) begin
      sync0 <= {sync0[0], ext_request_pin_zero_n_i};
      sync1 <= {sync1[0], ext_request_pin_one_n_i};
      // every keyboard line passes two flops before it is sampled
      kbd_sync <= {kbd_sync[3:0], keyboard_inputs_i};
      pcnt <= tick ? 3'h0 : pcnt + 3'h1;
      if (tick) begin
        last0 <= sync0[1];
        last1 <= sync1[1];
        kbd_sampled_o <= kbd_sync[7:4];
      end
      pending <= next_pending;
      timer_control_register[`PIC_BIT_REQ_ZERO] <= next_pending[0];
      timer_control_register[`PIC_BIT_REQ_ONE] <= next_pending[2];
      if (wsel_tc) begin
        timer_control_register[`PIC_BIT_TRIG_ZERO] <= w_data[`PIC_BIT_TRIG_ZERO];
        timer_control_register[`PIC_BIT_TRIG_ONE] <= w_data[`PIC_BIT_TRIG_ONE];
      end
      // release top level first, then mark newly granted one
      if (take)
        in_progress <= (leave ? (in_progress & ~(4'h1 << cur_top[1:0])) : in_progress)
                       | (4'h1 << win_lvl);
      else if (leave && cur_top != 3'h4)
        in_progress <= in_progress & ~(4'h1 << cur_top[1:0]);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        if (w_strb[0]) begin
          case (aw_addr)
            `PIC_OFF_ENABLE_ZERO: enable_reg_zero <= w_data[7:0];
            `PIC_OFF_ENABLE_ONE: enable_reg_one <= {2'h0, w_data[5:0]};
            `PIC_OFF_PRIO_HIGH_ZERO: prio_high_reg_zero <= {1'b0, w_data[6:0]};
            `PIC_OFF_PRIO_HIGH_ONE: prio_high_reg_one <= {2'h0, w_data[5:0]};
            `PIC_OFF_PRIO_LOW_ZERO: prio_low_reg_zero <= {1'b0, w_data[6:0]};
            `PIC_OFF_PRIO_LOW_ONE: prio_low_reg_one <= {2'h0, w_data[5:0]};
            `PIC_OFF_MASK: mask <= w_data[2:0];
            default: mask <= mask;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // read clears status; new events in the same cycle survive
      status <= (rd_status ? 3'h0 : status) | {ev0 || ev1, leave, take};
    end
  end
endmodule
`default_nettype wire

// >>> pic_intc_props.sv
// checker: bus handshakes, vectors, wake and keyboard sampling
// assumes a bind onto pic_intc, one clock, sync active-low reset
`timescale 1ns/1ns
`default_nettype none
module pic_intc_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and core side
  input wire logic ext_request_pin_zero_n_i,
  input wire logic [3:0] kbd_sampled_o,
  input wire logic irq_req_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  vec_range_a: assert property (
    irq_req_o |-> irq_vector_o[2:0] == 3'h3 && irq_vector_o <= 16'h0063)
    else $error("vector off the source grid");
  wake_low_a: assert property (
    (ce_i && !ext_request_pin_zero_n_i)[*3] |-> wake_o) else $error("no wake on low pin");
  kbd_rate_a: assert property (
    $changed(kbd_sampled_o) |=> $stable(kbd_sampled_o)[*5]) else $error("keyboard sampled too often");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response waits");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data waits");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce_i |=> s_axi_rvalid)
    else $error("read data late");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready && ce_i |=> !s_axi_bvalid)
    else $error("write response not retired");
  rdata_done_a: assert property (s_axi_rvalid && s_axi_rready && ce_i |=> !s_axi_rvalid)
    else $error("read data not retired");
endmodule
bind pic_intc pic_intc_chk chk_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_request_pin_zero_n_i(ext_request_pin_zero_n_i), .kbd_sampled_o(kbd_sampled_o),
  .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .wake_o(wake_o));
`default_nettype wire

// >>> pic_core_mdl.sv
// core model: vectors after a random instruction tail, returns on command
// assumes the controller's core-side pins on the same clock
`timescale 1ns/1ns
`default_nettype none
module pic_core_mdl (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // controller side
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  output logic irq_grant_o,
  output logic irq_return_o,
  // bench side
  input wire logic ret_cmd_i,
  output logic [15:0] vec_got_o,
  output logic [7:0] ngrant_o
);
  logic [1:0] wait_q;
  always @(posedge clk_i) begin
    irq_grant_o <= 1'b0;
    irq_return_o <= ret_cmd_i;
    if (!nrst_i) begin
      wait_q <= 2'h0;
      ngrant_o <= 8'h00;
    end else if (irq_grant_o && irq_req_i) begin
      vec_got_o <= irq_vector_i;
      ngrant_o <= ngrant_o + 8'h01;
    end else if (irq_req_i && wait_q == 2'h0) begin
      irq_grant_o <= 1'b1;
      wait_q <= 2'($urandom_range(3));
    end else if (irq_req_i) begin
      // stands for the instruction still finishing
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the interrupt controller
// assumes pic_intc, the core model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0, nrst_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pin0_n = 1'b1, pin1_n = 1'b1, ret_cmd = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, g;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] kbd = 4'h0;
  logic [14:0] src = 15'h0;
  logic [12:0] ph, pl, p;
  logic [15:0] e;
  logic [1:0] rsp;
  int fails = 0, checks = 0, n;
  wire logic awready, wready, bvalid, arready, rvalid, req, grant, ret, wake, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] vec, vec_got;
  wire logic [3:0] kbd_s;
  wire logic [7:0] ngrant;
  always #5 clk_i = ~clk_i;
  pic_intc dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_request_pin_zero_n_i(pin0_n), .ext_request_pin_one_n_i(pin1_n),
    .keyboard_inputs_i(kbd), .src_pulse_i(src), .irq_req_o(req), .irq_vector_o(vec),
    .irq_grant_i(grant), .irq_return_i(ret), .kbd_sampled_o(kbd_s), .wake_o(wake),
    .irq_o(irq));
  pic_core_mdl core_u (.clk_i(clk_i), .nrst_i(nrst_i), .irq_req_i(req),
    .irq_vector_i(vec), .irq_grant_o(grant), .irq_return_o(ret), .ret_cmd_i(ret_cmd),
    .vec_got_o(vec_got), .ngrant_o(ngrant));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n == 0 || !bvalid; n++) begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > 60) end_sim(1'b1);
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n == 0 || !rvalid; n++) begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (n > 60) end_sim(1'b1);
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic pend(input logic [14:0] m);
    src <= m;
    @(posedge clk_i);
    src <= 15'h0;
  endtask
  task automatic take(input logic [15:0] ev);
    g = ngrant;
    for (n = 0; ngrant === g; n++) begin
      @(posedge clk_i);
      if (n > 60) end_sim(1'b1);
    end
    chk({16'h0, vec_got}, {16'h0, ev});
  endtask
  // clear in the routine, then return
  task automatic fin(input logic [14:0] c);
    wr(8'h28, {17'h0, c});
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
  endtask
  task automatic prio(input logic [12:0] h, input logic [12:0] l);
    ph = h;
    pl = l;
    wr(8'h08, {25'h0, h[6:0]});
    wr(8'h0C, {26'h0, h[12:7]});
    wr(8'h10, {25'h0, l[6:0]});
    wr(8'h14, {26'h0, l[12:7]});
  endtask
  function automatic logic [15:0] wvec(input logic [12:0] q);
    int b;
    b = -1;
    for (int s = 0; s < 13; s++)
      if (q[s] && (b < 0 || {ph[s], pl[s]} > {ph[b], pl[b]})) b = s;
    return 16'h0003 + 16'(8 * b);
  endfunction
  task automatic end_sim(input logic hung);
    if (hung) fails++;
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(80408));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdr(8'h1C);
    chk(rd, 32'h0);
    rdr(8'h30);
    chk({30'h0, rsp}, 32'h2);
    // level request on pin 0 while its own enable is off
    wr(8'h30, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h00, 32'h80);
    chk({30'h0, rsp}, 32'h0);
    pin0_n <= 1'b0;
    repeat (14) @(posedge clk_i);
    chk({31'h0, wake}, 32'h1);
    pin0_n <= 1'b1;
    repeat (14) @(posedge clk_i);
    chk({31'h0, req}, 32'h0);
    rdr(8'h18);
    chk(rd, 32'h2);
    wr(8'h24, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rdr(8'h20);
    chk(rd, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'h0);
    rdr(8'h18);
    chk(rd, 32'h0);
    // falling edge on pin 1 with the global enable off
    wr(8'h00, 32'h04);
    wr(8'h18, 32'h04);
    pin1_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    pin1_n <= 1'b1;
    repeat (12) @(posedge clk_i);
    rdr(8'h18);
    chk(rd, 32'hC);
    chk({31'h0, req}, 32'h0);
    wr(8'h00, 32'h84);
    take(16'h0013);
    rdr(8'h18);
    chk(rd, 32'h4);
    fin(15'h0004);
    // nesting: equal level waits, higher level preempts
    wr(8'h00, 32'hFF);
    wr(8'h04, 32'h3F);
    prio(13'h0010, 13'h000A);
    pend(15'h0008);
    take(16'h001B);
    pend(15'h0002);
    g = ngrant;
    repeat (8) @(posedge clk_i);
    chk({24'h0, ngrant}, {24'h0, g});
    pend(15'h0010);
    take(16'h0023);
    fin(15'h0010);
    g = ngrant;
    repeat (8) @(posedge clk_i);
    chk({24'h0, ngrant}, {24'h0, g});
    fin(15'h0008);
    take(16'h000B);
    fin(15'h0002);
    for (int r = 0; r < 8; r++) begin
      prio(13'($urandom), 13'($urandom));
      rdr(8'h14);
      chk(rd, {26'h0, pl[12:7]});
      kbd <= 4'($urandom);
      p = (13'($urandom) & 13'h1FFA) | 13'h1000;
      pend({2'h0, p});
      while (p != 13'h0) begin
        e = wvec(p);
        take(e);
        p[e[6:3]] = 1'b0;
        fin(15'h1 << e[6:3]);
      end
      chk({28'h0, kbd_s}, {28'h0, kbd});
    end
    end_sim(1'b0);
  end
endmodule
`default_nettype wire
